// [hdl/fsc_device.sv]
// Device end: colour sink control, one-shot flash and safety timer
`timescale 1ns/1ps
module fsc_device
  import fsc_pkg::*;
#(
  parameter int SAFE_CYC = FSC_SAFE_CYC,  // Cycles in one second
  parameter int PWM_CYC  = FSC_PWM_CYC    // Cycles in one modulator period
) (
  input  wire logic       clk,        // 125 MHz clock
  input  wire logic       rst,        // Synchronous reset, active high
  fsc_link_if.dev         link,       // Register access and trigger pin
  output logic [2:0]      sinkOn,     // Red, green, blue output on
  output logic [5:0]      sinkLevel,  // Current codes red 5:4, green 3:2, blue 1:0
  output logic            switchMode, // Outputs act as switches
  output logic            safetyTrip  // Safety tripped status
);

  localparam int SW = $clog2(SAFE_CYC + 1);
  localparam int PW = $clog2(PWM_CYC + 1);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [PW-1:0] dutyOf(input logic [2:0] bright);
    logic [PW-1:0] d;
    d = PW'(PWM_CYC) >> (3'd7 - bright);
    return (bright == 3'd0) ? '0 : d;
  endfunction

  // ---------------------------------------------------------------
  // Pin synchroniser
  // ---------------------------------------------------------------
  logic trigMeta_r;
  logic trigSync_r;
  logic trigPrev_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      trigMeta_r <= 1'b0;
      trigSync_r <= 1'b0;
      trigPrev_r <= 1'b0;
    end else begin
      trigMeta_r <= link.trigPin;
      trigSync_r <= trigMeta_r;
      trigPrev_r <= trigSync_r;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0] ctrl_r;
  logic [7:0] colour_r;
  logic [5:0] maxCur_r;
  logic       pinEn_r;
  logic [7:0] flash_r;
  logic [7:0] rdata_r;
  logic       tripped_r;

  logic wrCtrl;
  logic wrFlash;
  logic curAccess;
  assign wrCtrl    = link.regWr && link.regAddr == FSC_CTRL_OFS;
  assign wrFlash   = link.regWr && link.regAddr == FSC_FLASH_OFS;
  assign curAccess = (link.regWr || link.regRd) && link.regAddr == FSC_MAXCUR_OFS;

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r   <= FSC_CTRL_RST;
      colour_r <= FSC_COLOUR_RST;
      maxCur_r <= FSC_MAXCUR_RST;
      pinEn_r  <= FSC_PIN_RST;
      flash_r  <= FSC_FLASH_RST;
    end else if (link.regWr) begin
      if (wrCtrl) ctrl_r <= link.regWdata;
      if (link.regAddr == FSC_COLOUR_OFS) colour_r <= link.regWdata;
      if (link.regAddr == FSC_MAXCUR_OFS) maxCur_r <= link.regWdata[5:0];
      if (link.regAddr == FSC_PIN_OFS) pinEn_r <= link.regWdata[FSC_PIN_EN_BIT];
      if (wrFlash) flash_r <= link.regWdata & ~(8'h01 << FSC_TRIPPED_BIT);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else if (link.regRd) begin
      unique case (link.regAddr)
        FSC_CTRL_OFS:   rdata_r <= ctrl_r;
        FSC_COLOUR_OFS: rdata_r <= colour_r;
        FSC_MAXCUR_OFS: rdata_r <= {2'h0, maxCur_r};
        FSC_PIN_OFS:    rdata_r <= 8'(pinEn_r) << FSC_PIN_EN_BIT;
        FSC_FLASH_OFS:  rdata_r <= flash_r | (8'(tripped_r) << FSC_TRIPPED_BIT);
        default:        rdata_r <= 8'h00;
      endcase
    end
  end
  assign link.regRdata = rdata_r;

  logic       modEn;
  logic       colEn;
  logic [2:0] switches;
  logic       flashMode;
  logic [2:0] safeEn;
  logic [2:0] extSel;
  logic       trig;
  assign modEn     = ctrl_r[FSC_MOD_EN_BIT];
  assign colEn     = ctrl_r[FSC_COL_EN_BIT];
  assign switches  = ctrl_r[FSC_SWITCH_LSB +: 3];
  assign flashMode = flash_r[FSC_FLASH_BIT];
  assign safeEn    = flash_r[FSC_SAFE_EN_LSB +: 3];
  assign extSel    = flash_r[FSC_EXT_SEL_LSB +: 3];
  assign trig      = pinEn_r && trigSync_r;

  // ---------------------------------------------------------------
  // One-shot flash sequencing
  // ---------------------------------------------------------------
  logic armed_r;
  logic pulse_r;
  logic spent_r;
  logic flashArm;
  assign flashArm = wrFlash && link.regWdata[FSC_FLASH_BIT] && !flashMode;

  always_ff @(posedge clk) begin
    if (rst) begin
      armed_r <= 1'b0;
      pulse_r <= 1'b0;
      spent_r <= 1'b0;
    end else if (!flashMode) begin
      armed_r <= flashArm;
      pulse_r <= 1'b0;
      spent_r <= 1'b0;
    end else if (armed_r && trig && !trigPrev_r) begin
      armed_r <= 1'b0;
      pulse_r <= 1'b1;
    end else if (pulse_r && !trig) begin
      pulse_r <= 1'b0;
      spent_r <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Safety timer
  // ---------------------------------------------------------------
  logic [SW-1:0] safeCnt_r;
  logic          anySafe;
  logic          countOn;
  assign anySafe = |safeEn;
  assign countOn = flashMode ? trig : 1'b1;

  always_ff @(posedge clk) begin
    if (rst) begin
      safeCnt_r <= '0;
      tripped_r <= 1'b0;
    end else if (!anySafe) begin
      safeCnt_r <= '0;
      tripped_r <= 1'b0;
    end else if (!tripped_r) begin
      if ((!flashMode && curAccess) || (flashMode && trig && !trigPrev_r)) begin
        safeCnt_r <= '0;
      end else if (countOn) begin
        safeCnt_r <= safeCnt_r + SW'(1);
        if (safeCnt_r == SW'(SAFE_CYC - 1)) begin
          tripped_r <= 1'b1;
        end
      end
    end
  end
  assign safetyTrip = tripped_r;

  // ---------------------------------------------------------------
  // Internal modulator
  // ---------------------------------------------------------------
  logic [PW-1:0] pwmCnt_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      pwmCnt_r <= '0;
    end else if (pwmCnt_r == PW'(PWM_CYC - 1)) begin
      pwmCnt_r <= '0;
    end else begin
      pwmCnt_r <= pwmCnt_r + PW'(1);
    end
  end

  logic pwmOn;
  assign pwmOn = pwmCnt_r < dutyOf(colour_r[FSC_BRIGHT_LSB +: 3]);

  // ---------------------------------------------------------------
  // Output drive
  // ---------------------------------------------------------------
  logic [2:0] onNxt;
  logic [5:0] levelNxt;

  always_comb begin
    for (int ch = 0; ch < 3; ch++) begin
      onNxt[ch] = colEn && switches[ch];
      if (modEn) onNxt[ch] = onNxt[ch] && pwmOn;
      if (!flashMode && pinEn_r && extSel[ch]) begin
        onNxt[ch] = onNxt[ch] && trig;
      end
      levelNxt[2*ch +: 2] = maxCur_r[2*ch +: 2];
      if (flashMode && extSel[ch]) begin
        if (pulse_r) begin
          onNxt[ch]           = 1'b1;
          levelNxt[2*ch +: 2] = FSC_CUR_FULL;
        end else if (spent_r) begin
          onNxt[ch] = 1'b0;
        end
      end
      if (tripped_r && safeEn[ch]) onNxt[ch] = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sinkOn     <= 3'h0;
      sinkLevel  <= 6'h00;
      switchMode <= FSC_CTRL_RST[FSC_SW_SEL_BIT];
    end else begin
      sinkOn     <= onNxt;
      sinkLevel  <= levelNxt;
      switchMode <= ctrl_r[FSC_SW_SEL_BIT];
    end
  end

endmodule // fsc_device

// [hdl/fsc_host.sv]
// Host end: forwards register commands and drives the trigger pin
`timescale 1ns/1ps
module fsc_host
  import fsc_pkg::*;
(
  input  wire logic       clk,       // 125 MHz clock
  input  wire logic       rst,       // Synchronous reset, active high
  input  wire logic [7:0] cmdAddr,   // Register address
  input  wire logic [7:0] cmdWdata,  // Write data
  input  wire logic       cmdWr,     // Write strobe
  input  wire logic       cmdRd,     // Read strobe
  output logic      [7:0] cmdRdata,  // Read data, cycle after cmdRd
  input  wire logic       trigReq,   // Requested trigger level
  fsc_link_if.host        link       // Link to the device
);

  // ---------------------------------------------------------------
  // Register path
  // ---------------------------------------------------------------
  // Software orders the setup sequences; one strobe is one full access.
  assign link.regAddr  = cmdAddr;
  assign link.regWdata = cmdWdata;
  assign link.regWr    = cmdWr;
  assign link.regRd    = cmdRd;
  assign cmdRdata      = link.regRdata;

  // ---------------------------------------------------------------
  // Trigger pin
  // ---------------------------------------------------------------
  logic flashShadow_r;
  logic holdLow_r;
  logic trig_r;
  logic setFlash;
  assign setFlash = cmdWr && cmdAddr == FSC_FLASH_OFS && cmdWdata[FSC_FLASH_BIT];

  always_ff @(posedge clk) begin
    if (rst) begin
      flashShadow_r <= 1'b0;
    end else if (cmdWr && cmdAddr == FSC_FLASH_OFS) begin
      flashShadow_r <= cmdWdata[FSC_FLASH_BIT];
    end
  end

  // Pin is forced low around the write that turns flash mode on
  always_ff @(posedge clk) begin
    if (rst) begin
      holdLow_r <= 1'b0;
      trig_r    <= 1'b0;
    end else begin
      holdLow_r <= setFlash && !flashShadow_r;
      trig_r    <= trigReq && !(setFlash && !flashShadow_r) && !holdLow_r;
    end
  end
  assign link.trigPin = trig_r;

endmodule // fsc_host

// [hdl/fsc_link_if.sv]
// Link between the host end and the flash safety device end
`timescale 1ns/1ps
interface fsc_link_if;
  logic [7:0] regAddr;   // Register address of an access
  logic [7:0] regWdata;  // Write data
  logic       regWr;     // One complete write sequence
  logic       regRd;     // One complete read sequence
  logic [7:0] regRdata;  // Read data, one cycle after regRd
  logic       trigPin;   // Trigger / external modulation pin

  modport dev  (input regAddr, regWdata, regWr, regRd, trigPin, output regRdata);
  modport host (output regAddr, regWdata, regWr, regRd, trigPin, input regRdata);
endinterface

// [hdl/fsc_pkg.sv]
// Package for the flash safety controller: register map, fields, timing
package fsc_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] FSC_CTRL_OFS   = 8'h00;
  localparam logic [7:0] FSC_COLOUR_OFS = 8'h01;
  localparam logic [7:0] FSC_MAXCUR_OFS = 8'h02;
  localparam logic [7:0] FSC_PIN_OFS    = 8'h06;
  localparam logic [7:0] FSC_FLASH_OFS  = 8'h08;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int FSC_MOD_EN_BIT   = 7;   // internal_modulation_enable
  localparam int FSC_COL_EN_BIT   = 6;   // colour_outputs_enable
  localparam int FSC_SW_SEL_BIT   = 5;   // sink_or_switch_select
  localparam int FSC_SWITCH_LSB   = 1;   // blue_switch .. red_switch at 1..3
  localparam int FSC_BRIGHT_LSB   = 1;   // brightness field 3:1 of colour reg
  localparam int FSC_PIN_EN_BIT   = 4;   // trigger-pin enable
  localparam int FSC_FLASH_BIT    = 0;   // flash mode
  localparam int FSC_SAFE_EN_LSB  = 1;   // safety enables blue..red at 1..3
  localparam int FSC_TRIPPED_BIT  = 4;   // read-only safety tripped
  localparam int FSC_EXT_SEL_LSB  = 5;   // external selects blue..red at 5..7

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] FSC_CTRL_RST   = 8'h20;
  localparam logic [7:0] FSC_COLOUR_RST = 8'h00;
  localparam logic [5:0] FSC_MAXCUR_RST = 6'h00;
  localparam logic       FSC_PIN_RST    = 1'b0;
  localparam logic [7:0] FSC_FLASH_RST  = 8'h00;
  localparam logic [1:0] FSC_CUR_FULL   = 2'h3;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam longint FSC_CLK_HZ      = 125000000;
  localparam longint FSC_SAFE_TIME_MS = 1000;
  localparam longint FSC_PWM_HZ      = 20000;
  localparam int FSC_SAFE_CYC = int'((FSC_CLK_HZ * FSC_SAFE_TIME_MS) / 1000);
  localparam int FSC_PWM_CYC  = int'(FSC_CLK_HZ / FSC_PWM_HZ);

endpackage

// [sim/flash_safety_control_tb.sv]
// Testbench joining host and device ends through the link
`timescale 1ns/1ps
module flash_safety_control_tb;
  import fsc_pkg::*;
  localparam int SAFE = 200;
  typedef struct packed {
    logic [10:0] v;
    logic [10:0] m;
  } fsc_note_t;
  logic       clk, rst, cmdWr, cmdRd, trigReq, rdD, obs, switchMode, safetyTrip;
  logic [7:0] cmdAddr, cmdWdata, cmdRdata;
  logic [2:0] sinkOn, sw;
  logic [5:0] sinkLevel, cur;
  logic [7:0] ofs [6] = '{8'h00, 8'h01, 8'h02, 8'h06, 8'h08, 8'h05};
  logic [7:0] rv [6]  = '{8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  int         nFail = 0;
  int         samplesChecked = 0;
  fsc_note_t  q[$];
  fsc_note_t  n;
  fsc_link_if link();
  fsc_host u_fsc_host (.clk(clk), .rst(rst), .cmdAddr(cmdAddr), .cmdWdata(cmdWdata),
    .cmdWr(cmdWr), .cmdRd(cmdRd), .cmdRdata(cmdRdata), .trigReq(trigReq), .link(link));
  fsc_device #(.SAFE_CYC(SAFE), .PWM_CYC(64)) u_fsc_device (.clk(clk), .rst(rst),
    .link(link), .sinkOn(sinkOn), .sinkLevel(sinkLevel), .switchMode(switchMode),
    .safetyTrip(safetyTrip));
  fsc_link_sva u_sva (.clk(clk), .rst(rst), .regAddr(link.regAddr),
    .regWdata(link.regWdata), .regWr(link.regWr), .regRd(link.regRd),
    .regRdata(link.regRdata), .trigPin(link.trigPin), .sinkOn(sinkOn),
    .sinkLevel(sinkLevel), .safetyTrip(safetyTrip));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic reportAndStop();
    if (nFail == 0 && samplesChecked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [10:0] s, input fsc_note_t e);
    samplesChecked++;
    if ((s & e.m) !== (e.v & e.m)) begin
      nFail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e.v & e.m, s & e.m);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cmdAddr <= a;
    cmdWdata <= d;
    cmdWr <= 1'b1;
    @(posedge clk);
    cmdWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] d);
    q.push_back('{{3'h0, d}, 11'h7ff});
    @(posedge clk);
    cmdAddr <= a;
    cmdRd <= 1'b1;
    @(posedge clk);
    cmdRd <= 1'b0;
  endtask
  task automatic look(input logic [10:0] v, input logic [10:0] m);
    q.push_back('{v, m});
    @(posedge clk);
    obs <= 1'b1;
    @(posedge clk);
    obs <= 1'b0;
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge clk);
  endtask
  task automatic trig(input logic v);
    @(posedge clk);
    trigReq <= v;
  endtask
  // ---------------------------------------------------------------
  // Clock, monitor and watchdog
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    rdD <= cmdRd;
    if (rdD || obs) begin
      n = q.pop_front();
      chk(rdD ? "rdata" : "outputs",
        rdD ? {3'h0, cmdRdata} : {switchMode, safetyTrip, sinkLevel, sinkOn}, n);
    end
  end
  initial begin
    idle(12000);
    nFail++;
    reportAndStop();
  end
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    {rst, cmdWr, cmdRd, trigReq, obs, cmdAddr, cmdWdata} = {1'b1, 20'h0};
    void'($urandom(32'h7fe467f3));
    idle(10);
    rst <= 1'b0;
    look({1'b1, 10'h000}, 11'h7ff);
    foreach (ofs[i]) rd(ofs[i], rv[i]);
    repeat (4) begin
      cur = 6'($urandom);
      sw = 3'($urandom);
      wr(FSC_MAXCUR_OFS, {2'h0, cur});
      wr(FSC_CTRL_OFS, {4'h4, sw, 1'b0});
      idle(4);
      look({2'h0, cur, sw}, 11'h7ff);
      rd(FSC_MAXCUR_OFS, {2'h0, cur});
    end
    wr(FSC_CTRL_OFS, 8'h4e);
    wr(FSC_FLASH_OFS, 8'h80);
    trig(1'b1);
    idle(8);
    look({2'h0, cur, 3'b111}, 11'h7ff);
    wr(FSC_PIN_OFS, 8'h10);
    trig(1'b0);
    idle(8);
    look({2'h0, cur, 3'b011}, 11'h7ff);
    trig(1'b1);
    idle(8);
    look({2'h0, cur, 3'b111}, 11'h7ff);
    trig(1'b0);
    wr(FSC_PIN_OFS, 8'h00);
    wr(FSC_COLOUR_OFS, 8'h0e);
    wr(FSC_CTRL_OFS, 8'hce);
    idle(8);
    look({2'h0, cur, 3'b111}, 11'h7ff);
    wr(FSC_COLOUR_OFS, 8'h00);
    idle(8);
    look({2'h0, cur, 3'b000}, 11'h7ff);
    wr(FSC_MAXCUR_OFS, 8'h1b);
    wr(FSC_CTRL_OFS, 8'h4e);
    wr(FSC_FLASH_OFS, 8'h08);
    repeat (3) begin
      idle(120);
      rd(FSC_MAXCUR_OFS, 8'h1b);
    end
    look({2'h0, 6'h1b, 3'b111}, 11'h7ff);
    idle(SAFE + 20);
    look({2'h1, 6'h1b, 3'b011}, 11'h7ff);
    rd(FSC_FLASH_OFS, 8'h18);
    wr(FSC_FLASH_OFS, 8'h08);
    rd(FSC_MAXCUR_OFS, 8'h1b);
    look({2'h1, 6'h1b, 3'b011}, 11'h7ff);
    wr(FSC_FLASH_OFS, 8'h00);
    idle(4);
    look({2'h0, 6'h1b, 3'b111}, 11'h7ff);
    wr(FSC_MAXCUR_OFS, 8'h00);
    wr(FSC_CTRL_OFS, 8'h40);
    trig(1'b1);
    wr(FSC_FLASH_OFS, 8'h01);
    trig(1'b0);
    wr(FSC_PIN_OFS, 8'h10);
    wr(FSC_CTRL_OFS, 8'h4c);
    wr(FSC_FLASH_OFS, 8'h81);
    repeat (2) begin
      trig(1'b1);
      idle(20);
      look({2'h0, 6'h30, 3'b110}, 11'h7ff);
      trig(1'b0);
      idle(8);
      look({2'h0, 6'h00, 3'b010}, 11'h607);
      trig(1'b1);
      idle(20);
      look({2'h0, 6'h00, 3'b010}, 11'h607);
      trig(1'b0);
      wr(FSC_FLASH_OFS, 8'h80);
      wr(FSC_FLASH_OFS, 8'h89);
      idle(SAFE + 50);
    end
    trig(1'b1);
    idle(SAFE + 20);
    look({2'h1, 6'h00, 3'b010}, 11'h607);
    trig(1'b0);
    wr(FSC_FLASH_OFS, 8'h10);
    rd(FSC_FLASH_OFS, 8'h00);
    idle(8);
    reportAndStop();
  end
endmodule // flash_safety_control_tb

// [sim/fsc_link_sva.sv]
// Checker on the link between the two ends and on the device outputs
`timescale 1ns/1ps
module fsc_link_sva
  import fsc_pkg::*;
(
  input wire logic       clk,        // Clock
  input wire logic       rst,        // Synchronous reset
  input wire logic [7:0] regAddr,    // Access address
  input wire logic [7:0] regWdata,   // Write data
  input wire logic       regWr,      // Write sequence
  input wire logic       regRd,      // Read sequence
  input wire logic [7:0] regRdata,   // Read data
  input wire logic       trigPin,    // Trigger pin
  input wire logic [2:0] sinkOn,     // Outputs on
  input wire logic [5:0] sinkLevel,  // Current codes
  input wire logic       safetyTrip  // Tripped status
);
  logic [7:0] ctl_r;
  logic [7:0] fl_r;
  logic [5:0] cur_r;
  logic       pin_r;
  logic [2:0] qt_r;
  logic [5:0] th_r;
  // ---------------------------------------------------------------
  // Shadow registers and quiet counter
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_r <= FSC_CTRL_RST;
      fl_r  <= FSC_FLASH_RST;
      cur_r <= FSC_MAXCUR_RST;
      pin_r <= FSC_PIN_RST;
    end else if (regWr) begin
      if (regAddr == FSC_CTRL_OFS) ctl_r <= regWdata;
      if (regAddr == FSC_FLASH_OFS) fl_r <= regWdata & 8'hef;
      if (regAddr == FSC_MAXCUR_OFS) cur_r <= regWdata[5:0];
      if (regAddr == FSC_PIN_OFS) pin_r <= regWdata[4];
    end
  end
  always_ff @(posedge clk) begin
    th_r <= {th_r[4:0], trigPin};
    if (rst || regWr) qt_r <= 3'h0;
    else if (qt_r != 3'h7) qt_r <= qt_r + 3'h1;
  end
  wire calm   = (qt_r == 3'h7) && !fl_r[0] && !ctl_r[7] && !safetyTrip;
  wire onRed  = ctl_r[6] && ctl_r[3];
  wire extRed = pin_r && fl_r[7];
  wire anyEn  = |fl_r[3:1];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_out_direct: assert property (calm && !extRed |-> sinkOn[2] == onRed)
    else $error("red output differs from its switch");
  a_trig_high: assert property (calm && extRed && onRed && th_r == 6'h3f |-> sinkOn[2])
    else $error("red output off with trigger high");
  a_trig_low: assert property (calm && extRed && th_r == 6'h00 |-> !sinkOn[2])
    else $error("red output on with trigger low");
  a_level_copy: assert property (qt_r == 3'h7 && !fl_r[0] |-> sinkLevel == cur_r)
    else $error("current codes differ from register");
  a_trip_off: assert property (safetyTrip && $past(safetyTrip) && fl_r[3] && $past(fl_r[3])
    |-> !sinkOn[2])
    else $error("tripped red output still on");
  a_trip_hold: assert property ($past(safetyTrip) && $past(anyEn) && !$past(regWr)
    |-> safetyTrip)
    else $error("trip cleared with a safety enable set");
  a_trip_read: assert property ($past(regRd) && $past(regAddr) == FSC_FLASH_OFS
    |-> regRdata[FSC_TRIPPED_BIT] == $past(safetyTrip))
    else $error("status bit differs from trip");
  a_flash_low: assert property (regWr && regAddr == FSC_FLASH_OFS && regWdata[0] && !fl_r[0]
    |=> !trigPin)
    else $error("trigger high as flash mode is set");
endmodule // fsc_link_sva
